// [rtl/bc_seq_pkg.sv]
/*
 Shared constants and carriers for the bus-controller option sequencer.
 Assumes a single 125 MHz clock domain.
*/
package bc_seq_pkg;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int CLK_MHZ = 125;
	// option select stability after strobe
	localparam int SEL_HOLD_NS = 1000;
	localparam int SEL_HOLD_CYC = (SEL_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// good-block pulse
	localparam int GOOD_BLOCK_NS = 500;
	localparam int GOOD_BLOCK_CYC = (GOOD_BLOCK_NS * 1000) / CLK_PERIOD_PS;
	// bus bit time (1 us) and half bit
	localparam int BIT_NS = 1000;
	localparam int HALF_BIT_CYC = (BIT_NS * 1000) / CLK_PERIOD_PS / 2;
	// byte strobe pulse width and gap
	localparam int STROBE_CYC = 4;
	// word field positions
	localparam int TR_BIT = 10;
	localparam int WC_LSB = 0;
	localparam int WC_W = 5;
	localparam int WORD_W = 16;
	localparam int FRAME_BITS = 20;
	localparam int RX_TIMEOUT_CYC = 2000;

	typedef enum logic [1:0]
	{
		OP_MESSAGE = 2'h0,
		OP_COMMAND_ONLY = 2'h1,
		OP_DATA_ONLY = 2'h2,
		OP_MODE_DATA = 2'h3
	} op_e;

	typedef enum logic [1:0]
	{
		SYNC_DATA = 2'h0,
		SYNC_CMD_STAT = 2'h1
	} sync_e;

	typedef struct packed
	{
		logic pos;
		logic neg;
	} manchester_s;

	typedef struct packed
	{
		logic valid;
		logic is_cmd_stat;
		logic [15:0] word;
	} rx_word_s;
endpackage

// [rtl/manchester_tx.sv]
/*
 Manchester II word encoder with sync and odd parity.
 Assumes start is a one-cycle pulse while idle; outputs are registered.
*/
`timescale 1ns/1ps
module manchester_tx
	import bc_seq_pkg::*;
#(
	parameter int HALF = HALF_BIT_CYC
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic sync_cmd,
	input wire logic [15:0] word,
	output logic busy,
	output manchester_s line
);
	initial
	begin
		if (HALF < 1)
			$error("half bit too short");
	end

	// 40 half-bit cells: 6 sync, 32 data, 2 parity
	logic [39:0] cells;
	logic [5:0] cell_cnt;
	logic [15:0] half_cnt;

	function automatic logic [39:0] build(input logic cmd, input logic [15:0] w);
		logic [39:0] c;
		logic par;
		c = '0;
		par = ~^w;
		c[39:34] = cmd ? 6'h38 : 6'h07;
		for (int i = 0; i < 16; i++)
			c[33 - 2 * i -: 2] = w[15 - i] ? 2'h2 : 2'h1;
		c[1:0] = par ? 2'h2 : 2'h1;
		return c;
	endfunction

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busy <= 1'b0;
			cells <= '0;
			cell_cnt <= '0;
			half_cnt <= '0;
		end
		else if (start && !busy)
		begin
			busy <= 1'b1;
			cells <= build(sync_cmd, word);
			cell_cnt <= 6'h27;
			half_cnt <= HALF[15:0] - 16'h1;
		end
		else if (busy)
		begin
			if (half_cnt != '0)
				half_cnt <= half_cnt - 16'h1;
			else if (cell_cnt == '0)
				busy <= 1'b0;
			else
			begin
				half_cnt <= HALF[15:0] - 16'h1;
				cell_cnt <= cell_cnt - 6'h1;
				cells <= {cells[38:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			line <= '0;
		else if (busy)
			line <= '{pos: cells[39], neg: ~cells[39]};
		else
			line <= '0;
	end
endmodule

// [rtl/bus_controller_option_sequencer.sv]
/*
 Bus-controller option sequencer: decodes four operations, fetches words
 from external latches over the byte highway, transmits them, and hands
 received words back to the subsystem.
 Assumes Manchester receive lines are already decoded to words upstream
 (rx_in, same clock); strap and control pins are asynchronous.
*/
`timescale 1ns/1ps
module bus_controller_option_sequencer
	import bc_seq_pkg::*;
#(
	parameter int GB_CYC = GOOD_BLOCK_CYC,
	parameter int TIMEOUT = RX_TIMEOUT_CYC
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic terminal_controller_select,
	input wire logic operation_select_a,
	input wire logic operation_select_b,
	input wire logic operation_strobe_n,
	input wire logic passive_monitor,
	input wire logic bus_select,
	input wire logic [4:0] terminal_address_lines,
	input wire logic terminal_address_parity,
	input wire logic [1:0] broadcast_recognition_enable,
	input wire logic [7:0] byte_highway_in,
	output logic [7:0] byte_highway_out,
	output logic byte_highway_oe,
	input wire logic transfer_acknowledge_n,
	input wire rx_word_s rx_in,
	output logic next_operation_ready,
	output logic command_word_latch_enable_n,
	output logic vector_or_data_word_enable_n,
	output logic transfer_request_n,
	output logic byte_transfer_strobe_n,
	output logic byte_select_high,
	output logic [4:0] current_word_index,
	output logic good_block_pulse_n,
	output logic mode_data_strobe_n,
	output logic status_word_strobe_n,
	output logic [1:0] tx_enable_n,
	output manchester_s tx_line,
	output logic [4:0] own_address,
	output logic address_ok,
	output logic rx_error
);
	initial
	begin
		if (GB_CYC < 1 || TIMEOUT < 1)
			$error("bad timing parameter");
	end

	typedef enum logic [3:0]
	{
		S_IDLE = 4'h0,
		S_HOLD = 4'h1,
		S_FETCH = 4'h3,
		S_SEND = 4'h2,
		S_WAIT_TX = 4'h6,
		S_RECEIVE = 4'h7,
		S_OUT = 4'h5,
		S_DONE = 4'h4
	} state_e;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [12:0] sync_a;
	logic [12:0] sync_b;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_a <= 13'h1fff;
			sync_b <= 13'h1fff;
		end
		else
		begin
			sync_a <= {terminal_controller_select, operation_select_a, operation_select_b,
				operation_strobe_n, passive_monitor, bus_select, transfer_acknowledge_n,
				broadcast_recognition_enable, 4'h0};
			sync_b <= sync_a;
		end
	end
	logic mode_bc;
	logic sel_a;
	logic sel_b;
	logic stb_n;
	logic monitor;
	logic bus_num;
	logic ack_n;
	logic [1:0] bcast_en;
	assign mode_bc = ~sync_b[12];
	assign sel_a = sync_b[11];
	assign sel_b = sync_b[10];
	assign stb_n = sync_b[9];
	assign monitor = sync_b[8];
	assign bus_num = sync_b[7];
	assign ack_n = sync_b[6];
	assign bcast_en = sync_b[5:4];

	// straps caught after reset release
	logic strap_done;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			own_address <= '0;
			address_ok <= 1'b0;
			strap_done <= 1'b0;
		end
		else if (!strap_done)
		begin
			strap_done <= 1'b1;
			own_address <= terminal_address_lines;
			address_ok <= ^{terminal_address_lines, terminal_address_parity};
		end
	end

	// ----------------------------------------------------------------
	// strobe edge and operation latch
	// ----------------------------------------------------------------
	logic stb_prev;
	logic stb_fall;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			stb_prev <= 1'b1;
		else
			stb_prev <= stb_n;
	end
	assign stb_fall = stb_prev && !stb_n;

	state_e state;
	op_e op;
	logic [15:0] hold_cnt;
	logic [15:0] word_buf;
	logic [5:0] words_left;
	logic fetch_data;
	logic remote_tx;
	logic [2:0] phase;
	logic [7:0] pcnt;
	logic tx_start;
	logic tx_sync_cmd;
	logic tx_busy;
	manchester_s tx_raw;
	logic [15:0] rx_cnt;
	logic [15:0] gb_cnt;
	logic [1:0] out_kind;

	// phase walk for a two-byte highway transfer
	function automatic logic phase_end(input logic [7:0] c);
		return c == 8'(STROBE_CYC - 1);
	endfunction

	// broadcast commands ignored on a bus with recognition disabled
	function automatic logic rx_accept(input rx_word_s w, input logic [1:0] en, input logic b);
		return w.valid && !(w.is_cmd_stat && w.word[15:11] == 5'h1f && !en[b]);
	endfunction

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= S_IDLE;
			op <= OP_MESSAGE;
			hold_cnt <= '0;
			word_buf <= '0;
			words_left <= '0;
			fetch_data <= 1'b0;
			remote_tx <= 1'b0;
			phase <= '0;
			pcnt <= '0;
			tx_start <= 1'b0;
			tx_sync_cmd <= 1'b0;
			rx_cnt <= '0;
			out_kind <= '0;
			rx_error <= 1'b0;
			current_word_index <= '0;
		end
		else
		begin
			tx_start <= 1'b0;
			case (state)
				S_IDLE:
				begin
					if (mode_bc && stb_fall)
					begin
						op <= op_e'({sel_b, sel_a});
						hold_cnt <= 16'(SEL_HOLD_CYC);
						state <= S_HOLD;
					end
					else if (mode_bc && monitor && op == OP_MODE_DATA && rx_accept(rx_in, bcast_en, bus_num))
					begin
						word_buf <= rx_in.word;
						out_kind <= rx_in.is_cmd_stat ? 2'h1 : 2'h2;
						phase <= '0;
						pcnt <= '0;
						state <= S_OUT;
					end
				end
				S_HOLD:
				begin
					// selects re-sampled at the end of the stable window
					if (hold_cnt != '0)
						hold_cnt <= hold_cnt - 16'h1;
					else
					begin
						op <= op_e'({sel_b, sel_a});
						fetch_data <= (op_e'({sel_b, sel_a}) == OP_DATA_ONLY);
						current_word_index <= '0;
						rx_error <= 1'b0;
						phase <= '0;
						pcnt <= '0;
						rx_cnt <= '0;
						state <= ({sel_b, sel_a} == 2'h3) ? S_RECEIVE : S_FETCH;
					end
				end
				S_FETCH:
				begin
					// two strobe pulses: high byte, then low byte
					if (phase_end(pcnt))
					begin
						pcnt <= '0;
						phase <= phase + 3'h1;
						if (phase == 3'h1)
							word_buf[15:8] <= byte_highway_in;
						if (phase == 3'h3)
						begin
							word_buf[7:0] <= byte_highway_in;
							state <= S_SEND;
						end
					end
					else
						pcnt <= pcnt + 8'h1;
				end
				S_SEND:
				begin
					tx_start <= 1'b1;
					tx_sync_cmd <= !fetch_data;
					state <= S_WAIT_TX;
					if (op == OP_MESSAGE && !fetch_data)
					begin
						// T/R bit taken as is: remote transmit means we receive
						remote_tx <= word_buf[TR_BIT];
						words_left <= (word_buf[4:0] == '0) ? 6'h20 : {1'b0, word_buf[4:0]};
					end
				end
				S_WAIT_TX:
				begin
					if (!tx_start && !tx_busy)
					begin
						phase <= '0;
						pcnt <= '0;
						if (op == OP_MESSAGE && !remote_tx && words_left != '0)
						begin
							fetch_data <= 1'b1;
							words_left <= words_left - 6'h1;
							if (fetch_data)
								current_word_index <= current_word_index + 5'h1;
							state <= S_FETCH;
						end
						else if (op == OP_MESSAGE)
						begin
							rx_cnt <= '0;
							state <= S_RECEIVE;
						end
						else
							state <= S_DONE;
					end
				end
				S_RECEIVE:
				begin
					rx_cnt <= rx_cnt + 16'h1;
					if (rx_cnt == 16'(TIMEOUT))
					begin
						rx_error <= 1'b1;
						state <= S_DONE;
					end
					else if (rx_accept(rx_in, bcast_en, bus_num))
					begin
						rx_cnt <= '0;
						word_buf <= rx_in.word;
						phase <= '0;
						pcnt <= '0;
						out_kind <= rx_in.is_cmd_stat ? 2'h1 : (op == OP_MODE_DATA ? 2'h2 : 2'h3);
						state <= S_OUT;
					end
				end
				S_OUT:
				begin
					if (out_kind == 2'h3 && phase == 3'h0 && ack_n)
						pcnt <= '0;
					else if (phase_end(pcnt))
					begin
						pcnt <= '0;
						phase <= phase + 3'h1;
						if (phase == 3'h4)
						begin
							if (out_kind == 2'h3)
								current_word_index <= current_word_index + 5'h1;
							if (monitor && op == OP_MODE_DATA)
								state <= S_IDLE;
							else if (out_kind == 2'h1 || op == OP_MODE_DATA)
								state <= S_DONE;
							else
							begin
								rx_cnt <= '0;
								state <= S_RECEIVE;
							end
						end
					end
					else
						pcnt <= pcnt + 8'h1;
				end
				S_DONE:
				begin
					if (stb_n)
						state <= S_IDLE;
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// subsystem handshake outputs
	// ----------------------------------------------------------------
	logic strobe_on;
	assign strobe_on = (phase == 3'h1 || phase == 3'h3);
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			next_operation_ready <= 1'b0;
			command_word_latch_enable_n <= 1'b1;
			vector_or_data_word_enable_n <= 1'b1;
			transfer_request_n <= 1'b1;
			byte_transfer_strobe_n <= 1'b1;
			byte_select_high <= 1'b1;
			mode_data_strobe_n <= 1'b1;
			status_word_strobe_n <= 1'b1;
			byte_highway_out <= '0;
			byte_highway_oe <= 1'b0;
		end
		else
		begin
			next_operation_ready <= (state == S_IDLE) && mode_bc;
			byte_select_high <= (phase < 3'h2);
			command_word_latch_enable_n <= !(state == S_FETCH && !fetch_data);
			vector_or_data_word_enable_n <= !(state == S_FETCH && op == OP_DATA_ONLY);
			transfer_request_n <= !((state == S_FETCH && fetch_data && op == OP_MESSAGE)
				|| (state == S_OUT && out_kind == 2'h3));
			byte_transfer_strobe_n <= !(strobe_on && (state == S_FETCH
				|| (state == S_OUT && out_kind == 2'h3)));
			status_word_strobe_n <= !(strobe_on && state == S_OUT && out_kind == 2'h1);
			mode_data_strobe_n <= !(strobe_on && state == S_OUT && out_kind == 2'h2);
			byte_highway_oe <= (state == S_OUT);
			byte_highway_out <= (phase < 3'h2) ? word_buf[15:8] : word_buf[7:0];
		end
	end

	// good-block timer after a clean received block
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			gb_cnt <= '0;
			good_block_pulse_n <= 1'b1;
		end
		else if (state == S_OUT && phase == 3'h4 && phase_end(pcnt) && out_kind == 2'h1
			&& op == OP_MESSAGE && remote_tx && !rx_error)
		begin
			gb_cnt <= 16'(GB_CYC);
			good_block_pulse_n <= 1'b0;
		end
		else if (gb_cnt > 16'h1)
			gb_cnt <= gb_cnt - 16'h1;
		else
		begin
			gb_cnt <= '0;
			good_block_pulse_n <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	manchester_tx #(.HALF(HALF_BIT_CYC)) u_tx
	(
		.clk(clk),
		.rstn(rstn),
		.start(tx_start),
		.sync_cmd(tx_sync_cmd),
		.word(word_buf),
		.busy(tx_busy),
		.line(tx_raw)
	);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_line <= '0;
			tx_enable_n <= 2'h3;
		end
		else
		begin
			tx_line <= tx_raw;
			tx_enable_n[0] <= !(tx_busy && !bus_num);
			tx_enable_n[1] <= !(tx_busy && bus_num);
		end
	end
endmodule

// [dv/bc_subsystem_model.sv]
/*
 Subsystem latch and acknowledge model for the option sequencer.
 Assumes the testbench loads cw, dw and ack_delay directly.
*/
`timescale 1ns/1ps
module bc_subsystem_model
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic cw_en_n,
	input wire logic dw_en_n,
	input wire logic req_n,
	input wire logic bsh,
	input wire logic oe,
	input wire logic [4:0] idx,
	output logic [7:0] hw,
	output logic ack_n
);
	logic [15:0] cw = 16'h0;
	logic [15:0] dw [32];
	int ack_delay = 1;
	int cnt;
	logic [7:0] last;
	logic [15:0] sel;
	logic drive;
	assign sel = !cw_en_n ? cw : dw[!dw_en_n ? 5'h0 : idx];
	assign drive = !cw_en_n || !dw_en_n || (!req_n && !oe);
	// released highway shows a changing pattern, not the last byte
	assign hw = drive ? (bsh ? sel[15:8] : sel[7:0]) : ~last;
	always @(posedge clk)
		last <= hw;
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn || req_n)
		begin
			cnt <= 0;
			ack_n <= 1'b1;
		end
		else
		begin
			cnt <= cnt + 1;
			if (cnt >= ack_delay)
				ack_n <= 1'b0;
		end
	end
endmodule

// [dv/bc_seq_chk.sv]
/*
 Port checker for the option sequencer.
 Assumes it is bound to the top module; one clock domain.
*/
`timescale 1ns/1ps
module bc_seq_chk
	import bc_seq_pkg::*;
#(
	parameter int GB_CYC = GOOD_BLOCK_CYC
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic terminal_controller_select,
	input wire logic operation_strobe_n,
	input wire logic [4:0] terminal_address_lines,
	input wire logic terminal_address_parity,
	input wire logic byte_highway_oe,
	input wire logic next_operation_ready,
	input wire logic command_word_latch_enable_n,
	input wire logic vector_or_data_word_enable_n,
	input wire logic byte_transfer_strobe_n,
	input wire logic byte_select_high,
	input wire logic good_block_pulse_n,
	input wire logic mode_data_strobe_n,
	input wire logic status_word_strobe_n,
	input wire logic [1:0] tx_enable_n,
	input wire manchester_s tx_line,
	input wire logic [4:0] own_address,
	input wire logic address_ok
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic strb;
	int gb_cnt;
	assign strb = byte_transfer_strobe_n & mode_data_strobe_n & status_word_strobe_n;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn || good_block_pulse_n)
			gb_cnt <= 0;
		else
			gb_cnt <= gb_cnt + 1;
	end
	property p_term_quiet;
		terminal_controller_select && $past(terminal_controller_select, 3) |-> tx_enable_n == 2'h3;
	endproperty
	a_term_quiet:
		assert property (p_term_quiet) else $error("transmit in terminal mode");
	property p_one_bus;
		tx_enable_n != 2'h0;
	endproperty
	a_one_bus:
		assert property (p_one_bus) else $error("both transmitters on");
	property p_polarity;
		!(tx_line.pos && tx_line.neg);
	endproperty
	a_polarity:
		assert property (p_polarity) else $error("line driven both ways");
	property p_gb_width;
		$rose(good_block_pulse_n) |-> gb_cnt == GB_CYC;
	endproperty
	a_gb_width:
		assert property (p_gb_width) else $error("good block width wrong");
	property p_pair;
		$fell(strb) && byte_select_high |-> ##[2:20] ($fell(strb) && !byte_select_high);
	endproperty
	a_pair:
		assert property (p_pair) else $error("low byte pulse missing");
	property p_width;
		$fell(strb) |-> !strb [*4] ##1 strb;
	endproperty
	a_width:
		assert property (p_width) else $error("strobe width wrong");
	property p_out_oe;
		!(status_word_strobe_n && mode_data_strobe_n) |-> byte_highway_oe;
	endproperty
	a_out_oe:
		assert property (p_out_oe) else $error("highway not driven on output");
	property p_in_free;
		!(command_word_latch_enable_n && vector_or_data_word_enable_n) |-> !byte_highway_oe;
	endproperty
	a_in_free:
		assert property (p_in_free) else $error("highway driven during fetch");
	property p_ready;
		$fell(operation_strobe_n) && next_operation_ready && !terminal_controller_select
			|-> ##[1:8] !next_operation_ready;
	endproperty
	a_ready:
		assert property (p_ready) else $error("ready did not drop");
	property p_tx_busy;
		$fell(&tx_enable_n) |-> !next_operation_ready;
	endproperty
	a_tx_busy:
		assert property (p_tx_busy) else $error("transmit without operation");
	property p_addr;
		$past(rstn, 2) |-> own_address == terminal_address_lines
			&& address_ok == ^{terminal_address_lines, terminal_address_parity};
	endproperty
	a_addr:
		assert property (p_addr) else $error("strap address wrong");
endmodule

// [dv/testbench.sv]
/*
 Self-checking bench for the option sequencer.
 Assumes the subsystem model and the checker beside it.
*/
`timescale 1ns/1ps
module testbench
	import bc_seq_pkg::*;
;
	logic clk = 0, rstn = 0, terminal_controller_select = 0, operation_select_a = 0;
	logic operation_select_b = 0, operation_strobe_n = 1, passive_monitor = 0, bus_select = 0;
	logic [4:0] terminal_address_lines = 5'h0b, current_word_index, own_address;
	logic terminal_address_parity = 0, transfer_acknowledge_n, byte_highway_oe, address_ok;
	logic [1:0] broadcast_recognition_enable = 2'h3, tx_enable_n;
	logic [7:0] byte_highway_in, byte_highway_out;
	rx_word_s rx_in = '0;
	manchester_s tx_line;
	logic next_operation_ready, command_word_latch_enable_n, vector_or_data_word_enable_n;
	logic transfer_request_n, byte_transfer_strobe_n, byte_select_high, good_block_pulse_n;
	logic mode_data_strobe_n, status_word_strobe_n, rx_error, gb_seen;
	logic [18:0] tx_q [$];
	logic [18:0] hw_q [$];
	int fail_count = 0, tests_run = 0;
	bus_controller_option_sequencer u_bus_controller_option_sequencer (.clk, .rstn,
		.terminal_controller_select, .operation_select_a, .operation_select_b,
		.operation_strobe_n, .passive_monitor, .bus_select, .terminal_address_lines,
		.terminal_address_parity, .broadcast_recognition_enable, .byte_highway_in,
		.byte_highway_out, .byte_highway_oe, .transfer_acknowledge_n, .rx_in,
		.next_operation_ready, .command_word_latch_enable_n, .vector_or_data_word_enable_n,
		.transfer_request_n, .byte_transfer_strobe_n, .byte_select_high, .current_word_index,
		.good_block_pulse_n, .mode_data_strobe_n, .status_word_strobe_n, .tx_enable_n,
		.tx_line, .own_address, .address_ok, .rx_error);
	bc_subsystem_model u_bc_subsystem_model (.clk, .rstn, .cw_en_n(command_word_latch_enable_n),
		.dw_en_n(vector_or_data_word_enable_n), .req_n(transfer_request_n),
		.bsh(byte_select_high), .oe(byte_highway_oe), .idx(current_word_index),
		.hw(byte_highway_in), .ack_n(transfer_acknowledge_n));
	initial
		forever #4 clk = ~clk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// 0: ready at lvl, 1: both queues empty, 2: transmit queue empty
	task wait_until(input int what, input logic lvl);
		int n;
		for (n = 0; n < 30000; n++)
		begin
			if (what == 0 ? next_operation_ready === lvl
				: tx_q.size() == 0 && (what == 2 || hw_q.size() == 0))
				break;
			@(posedge clk);
		end
		if (n == 30000)
		begin
			chk(0, 1);
			final_report();
		end
	endtask
	task op(input logic [1:0] o);
		wait_until(0, 1);
		@(posedge clk);
		{operation_select_b, operation_select_a} <= o;
		@(posedge clk);
		operation_strobe_n <= 1'b0;
		repeat (SEL_HOLD_CYC + 8) @(posedge clk);
		operation_strobe_n <= 1'b1;
	endtask
	task push_tx(input logic cs, input logic [15:0] w);
		tx_q.push_back({bus_select ? 2'h1 : 2'h2, cs, w});
	endtask
	task rx(input logic cs, input logic [15:0] w);
		@(posedge clk);
		rx_in <= '{valid: 1'b1, is_cmd_stat: cs, word: w};
		@(posedge clk);
		rx_in.valid <= 1'b0;
		repeat (40) @(posedge clk);
	endtask
	// bus word decoder: sync polarity, enable in use, data bits msb first
	initial
	begin
		logic [15:0] v;
		logic [2:0] s;
		forever
		begin
			@(posedge clk);
			while (tx_line !== 2'h0)
			begin
				s = {tx_enable_n, tx_line.pos};
				repeat (6 * HALF_BIT_CYC + HALF_BIT_CYC / 2) @(posedge clk);
				for (int i = 15; i >= 0; i--)
				begin
					v[i] = tx_line.pos;
					repeat (2 * HALF_BIT_CYC) @(posedge clk);
				end
				repeat (2 * HALF_BIT_CYC - HALF_BIT_CYC / 2) @(posedge clk);
				chk({s, v}, tx_q.size() ? tx_q.pop_front() : '1);
			end
		end
	end
	// highway output monitor: strobe kind, byte order, indicator
	initial
	begin
		logic [2:0] sn, sp, k;
		logic [7:0] b [2];
		logic [1:0] h;
		logic [18:0] e;
		int n;
		n = 0;
		sp = 3'h7;
		forever
		begin
			@(posedge clk);
			if (good_block_pulse_n === 1'b0)
				gb_seen = 1;
			sn = {status_word_strobe_n, mode_data_strobe_n, byte_transfer_strobe_n};
			if ((sp & ~sn) != 3'h0 && byte_highway_oe === 1'b1)
			begin
				k = sp & ~sn;
				b[n] = byte_highway_out;
				h[n] = byte_select_high;
				n++;
				if (n == 2)
				begin
					n = 0;
					e = hw_q.size() ? hw_q.pop_front() : '1;
					chk({k, transfer_request_n, h, b[0], b[1]},
						{e[18:16], e[18:16] != 3'h1, 2'b01, e[15:0]});
				end
			end
			sp = sn;
		end
	end
	initial
	begin
		logic [15:0] w, d, s;
		void'($urandom(32'ha2b20280));
		repeat (2) @(posedge clk);
		chk({next_operation_ready, tx_enable_n, good_block_pulse_n}, 4'h7);
		rstn <= 1'b1;
		wait_until(0, 1);
		chk({own_address, address_ok}, {terminal_address_lines, 1'b1});
		w = $urandom;
		u_bc_subsystem_model.cw = w;
		push_tx(1, w);
		op(2'h1);
		w = ($urandom & 16'hfbe0) | 16'h0002;
		u_bc_subsystem_model.ack_delay = 20;
		op(2'h0);
		u_bc_subsystem_model.cw = w;
		push_tx(1, w);
		for (int i = 0; i < 2; i++)
		begin
			u_bc_subsystem_model.dw[i] = $urandom;
			push_tx(0, u_bc_subsystem_model.dw[i]);
		end
		wait_until(1, 0);
		wait_until(0, 1);
		chk(rx_error, 1'b1);
		bus_select <= 1'b1;
		@(posedge clk);
		u_bc_subsystem_model.dw[0] = $urandom;
		push_tx(0, u_bc_subsystem_model.dw[0]);
		op(2'h2);
		wait_until(1, 0);
		bus_select <= 1'b0;
		u_bc_subsystem_model.ack_delay = 1;
		@(posedge clk);
		w = ($urandom & 16'hffe0) | 16'h0401;
		u_bc_subsystem_model.cw = w;
		push_tx(1, w);
		d = $urandom;
		s = $urandom;
		hw_q.push_back({3'h1, d});
		hw_q.push_back({3'h4, s});
		gb_seen = 0;
		op(2'h0);
		wait_until(2, 0);
		rx(0, d);
		rx(1, s);
		wait_until(0, 1);
		wait_until(1, 0);
		chk({gb_seen, rx_error}, 2'b10);
		d = $urandom;
		hw_q.push_back({3'h2, d});
		op(2'h3);
		rx(0, d);
		wait_until(0, 1);
		wait_until(1, 0);
		terminal_controller_select <= 1'b1;
		repeat (4) @(posedge clk);
		operation_strobe_n <= 1'b0;
		repeat (200) @(posedge clk);
		operation_strobe_n <= 1'b1;
		repeat (3000) @(posedge clk);
		terminal_controller_select <= 1'b0;
		rstn <= 1'b0;
		terminal_address_lines <= $urandom;
		terminal_address_parity <= $urandom;
		broadcast_recognition_enable <= 2'($urandom) & 2'h2;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		wait_until(0, 1);
		chk({own_address, address_ok},
			{terminal_address_lines, ^{terminal_address_lines, terminal_address_parity}});
		passive_monitor <= 1'b1;
		w = $urandom & 16'h7fff;
		d = $urandom;
		hw_q.push_back({3'h4, w});
		hw_q.push_back({3'h2, d});
		op(2'h3);
		rx(1, w);
		rx(0, d);
		// broadcast on bus 0 with recognition off must not come out
		w = $urandom | 16'hf800;
		rx(1, w);
		wait_until(1, 0);
		final_report();
	end
endmodule
bind bus_controller_option_sequencer bc_seq_chk #(.GB_CYC(GB_CYC)) u_bc_seq_chk (.clk, .rstn,
	.terminal_controller_select, .operation_strobe_n, .terminal_address_lines,
	.terminal_address_parity, .byte_highway_oe, .next_operation_ready,
	.command_word_latch_enable_n, .vector_or_data_word_enable_n, .byte_transfer_strobe_n,
	.byte_select_high, .good_block_pulse_n, .mode_data_strobe_n, .status_word_strobe_n,
	.tx_enable_n, .tx_line, .own_address, .address_ok);
